// [dv/fault_limit_response_regs_bench.sv]
`timescale 1ns/1ps

module fault_limit_response_regs_bench;
  logic core_clk, rst_n, supply_en, oc_p, ot_p, vin_p, vout_p, cmd_valid, cmd_write, rsp_valid, power_on, ramp, pgood;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, rd, oc_lim, vout;
  int          bad_count, compares, cycles;
  // code, write data, value read back, invalid-data flag expected
  logic [40:0] tbl [19] = '{
    {8'h46,16'h0032,16'h0032,1'b0}, {8'h46,16'h0033,16'h0032,1'b1},
    {8'h4A,16'h0028,16'h0028,1'b0}, {8'h46,16'h0028,16'h0032,1'b1},
    {8'h4A,16'h0007,16'h0028,1'b1}, {8'h4F,16'h008D,16'h0078,1'b1},
    {8'h51,16'h0078,16'h006E,1'b1}, {8'h51,16'h0019,16'h0019,1'b0},
    {8'h55,16'h005B,16'h0050,1'b1}, {8'h55,16'h0030,16'h0030,1'b0},
    {8'h5E,16'h0069,16'h0069,1'b0}, {8'h5E,16'h0068,16'h0069,1'b1},
    {8'h60,16'h01F5,16'h000A,1'b1}, {8'h60,16'h0000,16'h0000,1'b0},
    {8'h61,16'h000E,16'h000F,1'b1}, {8'h47,16'h0000,16'h00C0,1'b0},
    {8'h47,16'h0023,16'h00C0,1'b1}, {8'h50,16'h00FF,16'h00B8,1'b0},
    {8'h56,16'h0000,16'h00C0,1'b1}};

  host_model host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));

  // short millisecond so delay and rise fit a brief run
  fault_limit_response_regs #(.CYC_PER_MS(4)) DUT (.core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .supply_en(supply_en),
    .vout_tenths(vout), .oc_fault_pin(oc_p), .ot_fault_pin(ot_p), .vin_ov_pin(vin_p),
    .vout_ov_pin(vout_p), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .power_on(power_on),
    .ramp_active(ramp), .pgood(pgood), .oc_fault_limit_out(oc_lim), .oc_warn_limit_out(),
    .overheat_fault_limit_out(), .overheat_warning_limit_out(), .vin_ov_limit_out());

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // bounded wait for the power stage to reach a level
  task automatic wait_on(input logic lvl);
    for (int i = 0; i < 60 && power_on !== lvl; i++) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic pin);
    pin = 1'b1;
    repeat (6) @(negedge core_clk);
    pin = 1'b0;
  endtask

  // hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, supply_en, oc_p, ot_p, vin_p, vout_p} = 6'h00;
    vout = 16'h0070;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    host.xfer(1'b0, 8'h79, 16'h0000, rd);
    check("status at reset", rd, 16'h0800);
    foreach (tbl[k]) begin
      host.xfer(1'b1, tbl[k][40:33], tbl[k][32:17], rd);
      host.xfer(1'b0, tbl[k][40:33], 16'h0000, rd);
      check("register", rd, tbl[k][16:1]);
      host.xfer(1'b0, 8'h7E, 16'h0000, rd);
      check("invalid data", rd & 16'h0040, {9'h000, tbl[k][0], 6'h00});
      host.xfer(1'b1, 8'h7E, 16'h00C0, rd);
    end
    check("oc limit out", oc_lim, 16'h0032);
    // zero delay: the stage comes up at once and ramps
    supply_en = 1'b1;
    wait_on(1'b1);
    check("power on", power_on, 1'b1);
    check("ramp", ramp, 1'b1);
    pulse(oc_p);
    repeat (60) @(negedge core_clk);
    check("latched off", power_on, 1'b0);
    // a 2 ms turn-on delay keeps the stage down after supply_en is cycled off and on, with the pin already low
    host.xfer(1'b1, 8'h60, 16'h0002, rd);
    supply_en = 1'b0;
    repeat (2) @(negedge core_clk);
    supply_en = 1'b1;
    repeat (4) @(negedge core_clk);
    check("delay hold", power_on, 1'b0);
    wait_on(1'b1);
    pulse(ot_p);
    check("ot shut", power_on, 1'b0);
    wait_on(1'b1);
    check("ot restart", power_on, 1'b1);
    vin_p = 1'b1;
    repeat (8) @(negedge core_clk);
    check("ov off", power_on, 1'b0);
    vin_p = 1'b0;
    wait_on(1'b1);
    check("ov resume", power_on, 1'b1);
    @(negedge core_clk);
    check("pgood", pgood, 1'b1);
    pulse(vout_p);
    repeat (4) @(negedge core_clk);
    host.xfer(1'b0, 8'h79, 16'h0000, rd);
    check("status faults", rd & 16'hFF00, 16'hE000);
    host.xfer(1'b1, 8'h03, 16'h0000, rd);
    host.xfer(1'b0, 8'h79, 16'h0000, rd);
    check("status cleared", rd & 16'hFF00, 16'h0000);
    // hysteresis: between the thresholds the last state holds
    vout = 16'h0066;
    @(negedge core_clk);
    check("pgood hold high", pgood, 1'b1);
    vout = 16'h0063;
    @(negedge core_clk);
    check("pgood drop", pgood, 1'b0);
    vout = 16'h0068;
    @(negedge core_clk);
    check("pgood hold low", pgood, 1'b0);
    vout = 16'h0069;
    @(negedge core_clk);
    check("pgood rise", pgood, 1'b1);
    conclude();
  end
endmodule // fault_limit_response_regs_bench

// [dv/host_model.sv]
`timescale 1ns/1ps

// management host: one command at a time, answer awaited
module host_model (
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // drive at falling edge; released data lines show the inverse so stale data never passes
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data, output logic [15:0] rd);
    @(negedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code  <= code;
    cmd_wdata <= data;
    @(negedge core_clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~data;
    rd = rsp_valid ? rsp_rdata : 16'hDEAD;
  endtask
endmodule // host_model

// [hw/fault_limit_response_regs.sv]
`timescale 1ns/1ps
`include "fault_limit_regs.svh"

module fault_limit_response_regs #(
  parameter int CYC_PER_MS = `CLK_MHZ * 1000 * `TIME_UNIT_MS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        supply_en,
  input  wire logic [15:0] vout_tenths,
  input  wire logic        oc_fault_pin,
  input  wire logic        ot_fault_pin,
  input  wire logic        vin_ov_pin,
  input  wire logic        vout_ov_pin,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             power_on,
  output logic             ramp_active,
  output logic             pgood,
  output logic [15:0]      oc_fault_limit_out,
  output logic [15:0]      oc_warn_limit_out,
  output logic [15:0]      overheat_fault_limit_out,
  output logic [15:0]      overheat_warning_limit_out,
  output logic [15:0]      vin_ov_limit_out
);

  if (CYC_PER_MS < 1 || CYC_PER_MS >= (1 << `CYC_WIDTH)) begin : g_bad_cyc
    $error("fault_limit_response_regs: CYC_PER_MS out of counter range");
  end

  localparam logic [17:0] CYC_M1 = 18'(CYC_PER_MS - 1);

  localparam logic [15:0] LIM_LO [`LIM_COUNT] = '{`OC_F_MIN, `OC_W_MIN, `OT_F_MIN, `OT_W_MIN, `VIN_MIN,
                                                 `PG_MIN, `PG_MIN, `TON_DLY_MIN, `OUTPUT_RISE_TIME_MIN};
  localparam logic [15:0] LIM_HI [`LIM_COUNT] = '{`OC_F_MAX, `OC_W_MAX, `OT_F_MAX, `OT_W_MAX, `VIN_MAX,
                                                 `PG_MAX, `PG_MAX, `TON_DLY_MAX, `OUTPUT_RISE_TIME_MAX};
  localparam logic [15:0] LIM_GAP [`LIM_COUNT] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001, 16'h0001,
                                                  `PG_GAP, `PG_GAP, 16'h0001, 16'h0001};
  localparam fault_limit_pkg::cross_mode_t LIM_MODE [`LIM_COUNT] = '{
    fault_limit_pkg::CROSS_ABOVE, fault_limit_pkg::CROSS_BELOW,
    fault_limit_pkg::CROSS_ABOVE, fault_limit_pkg::CROSS_BELOW,
    fault_limit_pkg::CROSS_NONE,
    fault_limit_pkg::CROSS_ABOVE, fault_limit_pkg::CROSS_BELOW,
    fault_limit_pkg::CROSS_NONE, fault_limit_pkg::CROSS_NONE};

  fault_limit_pkg::regs_t r;
  fault_limit_pkg::regs_t n;
  logic [15:0]            ref_arr [`LIM_COUNT];
  logic [8:0]             lim_ok;
  logic                   oc_s;
  logic                   ot_s;
  logic                   vin_s;
  logic                   vout_s;

  //////////////////////////////////////////////////////////////////////////////
  // range and cross checks, one checker per limit slot

  // each paired limit is checked against its partner as held now, not as written
  assign ref_arr[`LIM_OC_F]     = r.lim[`LIM_OC_W];
  assign ref_arr[`LIM_OC_W]     = r.lim[`LIM_OC_F];
  assign ref_arr[`LIM_OT_F]     = r.lim[`LIM_OT_W];
  assign ref_arr[`LIM_OT_W]     = r.lim[`LIM_OT_F];
  assign ref_arr[`LIM_VIN]      = 16'h0000;
  assign ref_arr[`LIM_PG_ON]    = r.lim[`LIM_PG_OFF];
  assign ref_arr[`LIM_PG_OFF]   = r.lim[`LIM_PG_ON];
  assign ref_arr[`LIM_TON_DLY]  = 16'h0000;
  assign ref_arr[`LIM_OUTPUT_RISE_TIME] = 16'h0000;

  limit_check_if ck [`LIM_COUNT] ();

  for (genvar g = 0; g < `LIM_COUNT; g++) begin : g_chk
    assign ck[g].value   = cmd_wdata;
    assign ck[g].ref_val = ref_arr[g];
    assign lim_ok[g]     = ck[g].ok;
    limit_check #(
      .LO   (LIM_LO[g]),
      .HI   (LIM_HI[g]),
      .GAP  (LIM_GAP[g]),
      .MODE (LIM_MODE[g])
    ) u_chk (
      .chk (ck[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // next-state logic

  assign oc_s   = r.sync2[0];
  assign ot_s   = r.sync2[1];
  assign vin_s  = r.sync2[2];
  assign vout_s = r.sync2[3];

  function automatic logic [4:0] lim_slot(input logic [7:0] code);
    unique case (code)
      `CMD_OC_FAULT_LIMIT: lim_slot = {1'b1, `LIM_OC_F};
      `CMD_OC_WARN_LIMIT:  lim_slot = {1'b1, `LIM_OC_W};
      `CMD_OVERHEAT_FAULT_LIMIT: lim_slot = {1'b1, `LIM_OT_F};
      `CMD_OVERHEAT_WARNING_LIMIT:  lim_slot = {1'b1, `LIM_OT_W};
      `CMD_VIN_OV_LIMIT:   lim_slot = {1'b1, `LIM_VIN};
      `CMD_GOOD_ASSERT:    lim_slot = {1'b1, `LIM_PG_ON};
      `CMD_GOOD_DEASSERT:  lim_slot = {1'b1, `LIM_PG_OFF};
      `CMD_TURN_ON_DELAY:  lim_slot = {1'b1, `LIM_TON_DLY};
      `CMD_RISE_TIME:      lim_slot = {1'b1, `LIM_OUTPUT_RISE_TIME};
      default:             lim_slot = 5'h00;
    endcase
  endfunction

  function automatic logic rs_ok(input logic [2:0] rs);
    rs_ok = (rs == `RS_NEVER) || (rs == `RS_ALWAYS);
  endfunction

  always_comb begin
    logic [4:0] slot;
    logic       set_data;
    logic       set_cmd;
    logic       clr_all;
    logic [1:0] cml_clr;
    logic       tick;
    slot     = lim_slot(cmd_code);
    set_data = 1'b0;
    set_cmd  = 1'b0;
    clr_all  = 1'b0;
    cml_clr  = 2'h0;
    tick     = (r.cyc == CYC_M1);
    n        = r;
    // pins cross into this clock through two flops
    n.sync1     = {vout_ov_pin, vin_ov_pin, ot_fault_pin, oc_fault_pin};
    n.sync2     = r.sync1;
    n.rsp_valid = 1'b0;
    n.rsp_rdata = 16'h0000;

    // command decode: every command answers one cycle later
    if (cmd_valid) begin
      n.rsp_valid = 1'b1;
      if (cmd_write) begin
        unique case (cmd_code)
          `CMD_OC_FAULT_LIMIT, `CMD_OC_WARN_LIMIT, `CMD_OVERHEAT_FAULT_LIMIT, `CMD_OVERHEAT_WARNING_LIMIT,
          `CMD_VIN_OV_LIMIT, `CMD_GOOD_ASSERT, `CMD_GOOD_DEASSERT, `CMD_TURN_ON_DELAY,
          `CMD_RISE_TIME: begin
            if (lim_ok[slot[3:0]]) begin
              n.lim[slot[3:0]] = cmd_wdata;
            end else begin
              set_data = 1'b1;
            end
          end
          // fixed response and delay bits of the written byte are ignored
          `CMD_OC_FAULT_REACT: begin
            if (rs_ok(cmd_wdata[5:3])) n.oc_rs = cmd_wdata[5:3];
            else set_data = 1'b1;
          end
          `CMD_OT_FAULT_REACT: begin
            if (rs_ok(cmd_wdata[5:3])) n.ot_rs = cmd_wdata[5:3];
            else set_data = 1'b1;
          end
          `CMD_VIN_OV_REACT, `CMD_SUMMARY_STATUS: set_data = 1'b1;
          `CMD_CLEAR_FAULTS: clr_all = 1'b1;
          `CMD_COMM_STATUS:  cml_clr = cmd_wdata[7:6];
          default:           set_cmd = 1'b1;
        endcase
      end else begin
        unique case (cmd_code)
          `CMD_OC_FAULT_LIMIT, `CMD_OC_WARN_LIMIT, `CMD_OVERHEAT_FAULT_LIMIT, `CMD_OVERHEAT_WARNING_LIMIT,
          `CMD_VIN_OV_LIMIT, `CMD_GOOD_ASSERT, `CMD_GOOD_DEASSERT, `CMD_TURN_ON_DELAY,
          `CMD_RISE_TIME: n.rsp_rdata = r.lim[slot[3:0]];
          `CMD_OC_FAULT_REACT: n.rsp_rdata = {8'h00, `RSP_OC, r.oc_rs, `DT_NONE};
          `CMD_OT_FAULT_REACT: n.rsp_rdata = {8'h00, `RSP_OT, r.ot_rs, `DT_NONE};
          `CMD_VIN_OV_REACT:   n.rsp_rdata = {8'h00, `RST_VIN_REACT};
          `CMD_SUMMARY_STATUS: n.rsp_rdata = {r.vout_f, r.iout_f, r.input_f, 1'b0, ~r.pgood, 11'h000};
          `CMD_COMM_STATUS:    n.rsp_rdata = {8'h00, r.cml_inv_cmd, r.cml_inv_data, 6'h00};
          default:             set_cmd = 1'b1;
        endcase
      end
    end

    // sticky flags: a new event in the clearing cycle survives the clear
    n.cml_inv_data = set_data | (r.cml_inv_data & ~(clr_all | cml_clr[0]));
    n.cml_inv_cmd  = set_cmd | (r.cml_inv_cmd & ~(clr_all | cml_clr[1]));
    n.vout_f       = vout_s | (r.vout_f & ~clr_all);
    n.iout_f       = oc_s | (r.iout_f & ~clr_all);
    n.input_f      = vin_s | (r.input_f & ~clr_all);

    // millisecond timebase, restarted on every state change below
    n.cyc = tick ? 18'h00000 : r.cyc + 18'h00001;
    n.ms  = tick ? r.ms + 16'h0001 : r.ms;

    // supply sequencing; shutdown acts in the cycle after the synced fault
    unique case (r.st)
      fault_limit_pkg::ST_OFF: begin
        if (supply_en) n.st = vin_s ? fault_limit_pkg::ST_OV_HOLD : fault_limit_pkg::ST_DELAY;
      end
      fault_limit_pkg::ST_DELAY: begin
        if (!supply_en) n.st = fault_limit_pkg::ST_OFF;
        else if (vin_s) n.st = fault_limit_pkg::ST_OV_HOLD;
        else if (r.ms == r.lim[`LIM_TON_DLY]) n.st = fault_limit_pkg::ST_RISE;
      end
      fault_limit_pkg::ST_RISE, fault_limit_pkg::ST_ON: begin
        if (!supply_en) n.st = fault_limit_pkg::ST_OFF;
        else if (vin_s) n.st = fault_limit_pkg::ST_OV_HOLD;
        else if (oc_s)
          n.st = (r.oc_rs == `RS_ALWAYS) ? fault_limit_pkg::ST_DELAY : fault_limit_pkg::ST_LATCHED;
        else if (ot_s)
          n.st = (r.ot_rs == `RS_ALWAYS) ? fault_limit_pkg::ST_DELAY : fault_limit_pkg::ST_LATCHED;
        else if (r.st == fault_limit_pkg::ST_RISE && r.ms == r.lim[`LIM_OUTPUT_RISE_TIME])
          n.st = fault_limit_pkg::ST_ON;
      end
      fault_limit_pkg::ST_LATCHED: begin
        if (!supply_en) n.st = fault_limit_pkg::ST_OFF;
      end
      fault_limit_pkg::ST_OV_HOLD: begin
        if (!supply_en) n.st = fault_limit_pkg::ST_OFF;
        else if (!vin_s) n.st = fault_limit_pkg::ST_DELAY;
      end
      default: n.st = fault_limit_pkg::ST_OFF;
    endcase
    if (n.st != r.st) begin
      n.cyc = 18'h00000;
      n.ms  = 16'h0000;
    end
    n.power_on = (n.st == fault_limit_pkg::ST_RISE) || (n.st == fault_limit_pkg::ST_ON);
    n.ramp     = (n.st == fault_limit_pkg::ST_RISE);

    // power good with hysteresis between the two thresholds
    if (!r.power_on || vout_tenths < r.lim[`LIM_PG_OFF]) n.pgood = 1'b0;
    else if (vout_tenths >= r.lim[`LIM_PG_ON]) n.pgood = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      r                     <= '0;
      r.lim[`LIM_OC_F]      <= `RST_OC_F;
      r.lim[`LIM_OC_W]      <= `RST_OC_W;
      r.lim[`LIM_OT_F]      <= `RST_OT_F;
      r.lim[`LIM_OT_W]      <= `RST_OT_W;
      r.lim[`LIM_VIN]       <= `RST_VIN;
      r.lim[`LIM_PG_ON]     <= `RST_PG_ON;
      r.lim[`LIM_PG_OFF]    <= `RST_PG_OFF;
      r.lim[`LIM_TON_DLY]   <= `RST_TON_DLY;
      r.lim[`LIM_OUTPUT_RISE_TIME]  <= `RST_OUTPUT_RISE_TIME;
      r.oc_rs               <= `RS_ALWAYS;
      r.ot_rs               <= `RS_ALWAYS;
      r.st                  <= fault_limit_pkg::ST_OFF;
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state flops
  assign rsp_valid          = r.rsp_valid;
  assign rsp_rdata          = r.rsp_rdata;
  assign power_on           = r.power_on;
  assign ramp_active        = r.ramp;
  assign pgood              = r.pgood;
  assign oc_fault_limit_out = r.lim[`LIM_OC_F];
  assign oc_warn_limit_out  = r.lim[`LIM_OC_W];
  assign overheat_fault_limit_out = r.lim[`LIM_OT_F];
  assign overheat_warning_limit_out  = r.lim[`LIM_OT_W];
  assign vin_ov_limit_out   = r.lim[`LIM_VIN];

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_oc_fault_range: assert property (
    (cmd_valid && cmd_write && cmd_code == `CMD_OC_FAULT_LIMIT &&
     (cmd_wdata < `OC_F_MIN || cmd_wdata > `OC_F_MAX || cmd_wdata <= r.lim[`LIM_OC_W]))
    |=> (r.lim[`LIM_OC_F] == $past(r.lim[`LIM_OC_F])) && r.cml_inv_data)
    else $error("overcurrent fault limit took a bad value");

  a_oc_warn_cross: assert property (
    (cmd_valid && cmd_write && cmd_code == `CMD_OC_WARN_LIMIT &&
     cmd_wdata >= `OC_W_MIN && cmd_wdata <= `OC_W_MAX && cmd_wdata < r.lim[`LIM_OC_F])
    |=> r.lim[`LIM_OC_W] == $past(cmd_wdata))
    else $error("valid overcurrent warning write not stored");

  a_oc_react_read: assert property (
    (cmd_valid && !cmd_write && cmd_code == `CMD_OC_FAULT_REACT)
    |=> rsp_valid && rsp_rdata[7:6] == 2'h3 && rsp_rdata[2:0] == 3'h0)
    else $error("overcurrent reaction byte fixed bits wrong");

  a_retry_codes: assert property (
    (r.oc_rs == 3'h0 || r.oc_rs == 3'h7) && (r.ot_rs == 3'h0 || r.ot_rs == 3'h7))
    else $error("unsupported retry code held");

  a_retry_restart: assert property (
    (power_on && supply_en && !vin_s && ((oc_s && r.oc_rs == 3'h7) || (!oc_s && ot_s && r.ot_rs == 3'h7)))
    |=> (r.st == fault_limit_pkg::ST_DELAY) && !power_on)
    else $error("always-retry fault did not restart");

  a_no_delay_shut: assert property (
    (power_on && oc_s && supply_en && !vin_s) |=> !power_on)
    else $error("overcurrent shutdown delayed");

  a_ot_fault_range: assert property (
    (cmd_valid && cmd_write && cmd_code == `CMD_OVERHEAT_FAULT_LIMIT && cmd_wdata > 16'h008C)
    |=> $stable(r.lim[`LIM_OT_F]))
    else $error("overheat fault limit above range accepted");

  a_ot_react_read: assert property (
    (cmd_valid && !cmd_write && cmd_code == `CMD_OT_FAULT_REACT) |=> rsp_rdata[7:6] == 2'h2)
    else $error("overheat reaction bits wrong");

  a_ot_warn_range: assert property (
    r.lim[`LIM_OT_W] >= 16'h0019 && r.lim[`LIM_OT_W] <= 16'h007D && r.lim[`LIM_OT_W] < r.lim[`LIM_OT_F])
    else $error("overheat warning out of range");

  a_vin_range: assert property (
    r.lim[`LIM_VIN] >= 16'h0030 && r.lim[`LIM_VIN] <= 16'h005A)
    else $error("input overvoltage limit out of range");

  a_vin_resume: assert property (
    (r.st == fault_limit_pkg::ST_OV_HOLD && supply_en && !vin_s)
    |=> r.st == fault_limit_pkg::ST_DELAY && r.ms == 16'h0000 && !power_on)
    else $error("overvoltage removal did not resume startup");

  a_vin_react_read: assert property (
    (cmd_valid && !cmd_write && cmd_code == `CMD_VIN_OV_REACT) |=> rsp_rdata == 16'h00C0)
    else $error("overvoltage reaction byte wrong");

  a_pg_gap: assert property (
    {1'b0, r.lim[`LIM_PG_ON]} >= {1'b0, r.lim[`LIM_PG_OFF]} + 17'h00005)
    else $error("power good thresholds too close");

  a_turn_on_delay: assert property (
    $rose(power_on) |-> $past(r.ms) == $past(r.lim[`LIM_TON_DLY]))
    else $error("output rose before turn-on delay");

  a_rise_range: assert property (
    r.lim[`LIM_OUTPUT_RISE_TIME] >= 16'h000F && r.lim[`LIM_OUTPUT_RISE_TIME] <= 16'h01F4)
    else $error("rise time out of range");

  a_status_read: assert property (
    (cmd_valid && !cmd_write && cmd_code == `CMD_SUMMARY_STATUS)
    |=> rsp_rdata[12] == 1'b0 && rsp_rdata[10:8] == 3'h0 && rsp_rdata[11] == !$past(pgood))
    else $error("summary status layout wrong");

endmodule // fault_limit_response_regs

// [hw/limit_check.sv]
`timescale 1ns/1ps

module limit_check #(
  parameter logic [15:0]                LO   = 16'h0000,
  parameter logic [15:0]                HI   = 16'hFFFF,
  parameter logic [15:0]                GAP  = 16'h0001,
  parameter fault_limit_pkg::cross_mode_t MODE = fault_limit_pkg::CROSS_NONE
) (
  limit_check_if.checker_end chk
);

  if (LO > HI) begin : g_bad_range
    $error("limit_check: LO above HI");
  end

  logic [16:0] ref_plus;
  logic [16:0] val_plus;
  logic        in_range;
  logic        cross_ok;

  // 17-bit sums so a margin near full scale cannot wrap
  assign ref_plus = {1'b0, chk.ref_val} + {1'b0, GAP};
  assign val_plus = {1'b0, chk.value} + {1'b0, GAP};
  assign in_range = (chk.value >= LO) && (chk.value <= HI);

  always_comb begin
    unique case (MODE)
      fault_limit_pkg::CROSS_ABOVE: cross_ok = {1'b0, chk.value} >= ref_plus;
      fault_limit_pkg::CROSS_BELOW: cross_ok = val_plus <= {1'b0, chk.ref_val};
      fault_limit_pkg::CROSS_NONE:  cross_ok = 1'b1;
      default:                      cross_ok = 1'b0;
    endcase
  end

  assign chk.ok = in_range && cross_ok;

endmodule // limit_check

// [shared/fault_limit_pkg.sv]
package fault_limit_pkg;

  typedef enum logic [1:0] {CROSS_NONE, CROSS_ABOVE, CROSS_BELOW} cross_mode_t;

  typedef enum logic [2:0] {ST_OFF, ST_DELAY, ST_RISE, ST_ON, ST_LATCHED, ST_OV_HOLD} supply_state_t;

  typedef struct packed {
    logic [8:0][15:0] lim;
    logic [2:0]       oc_rs;
    logic [2:0]       ot_rs;
    logic             vout_f;
    logic             iout_f;
    logic             input_f;
    logic             cml_inv_cmd;
    logic             cml_inv_data;
    logic [3:0]       sync1;
    logic [3:0]       sync2;
    supply_state_t    st;
    logic [17:0]      cyc;
    logic [15:0]      ms;
    logic             power_on;
    logic             ramp;
    logic             pgood;
    logic             rsp_valid;
    logic [15:0]      rsp_rdata;
  } regs_t;

endpackage

// [shared/fault_limit_regs.svh]
`ifndef FAULT_LIMIT_REGS_SVH
`define FAULT_LIMIT_REGS_SVH

// command codes
`define CMD_CLEAR_FAULTS      8'h03
`define CMD_OC_FAULT_LIMIT    8'h46
`define CMD_OC_FAULT_REACT    8'h47
`define CMD_OC_WARN_LIMIT     8'h4A
`define CMD_OVERHEAT_FAULT_LIMIT    8'h4F
`define CMD_OT_FAULT_REACT    8'h50
`define CMD_OVERHEAT_WARNING_LIMIT     8'h51
`define CMD_VIN_OV_LIMIT      8'h55
`define CMD_VIN_OV_REACT      8'h56
`define CMD_GOOD_ASSERT       8'h5E
`define CMD_GOOD_DEASSERT     8'h5F
`define CMD_TURN_ON_DELAY     8'h60
`define CMD_RISE_TIME         8'h61
`define CMD_SUMMARY_STATUS    8'h79
`define CMD_COMM_STATUS       8'h7E

// limit table slots
`define LIM_OC_F              4'h0
`define LIM_OC_W              4'h1
`define LIM_OT_F              4'h2
`define LIM_OT_W              4'h3
`define LIM_VIN               4'h4
`define LIM_PG_ON             4'h5
`define LIM_PG_OFF            4'h6
`define LIM_TON_DLY           4'h7
`define LIM_OUTPUT_RISE_TIME          4'h8
`define LIM_COUNT             9

// accepted ranges (amps, deg C, volts, tenths of a volt, ms)
`define OC_F_MIN              16'h000F
`define OC_F_MAX              16'h0032
`define OC_W_MIN              16'h0008
`define OC_W_MAX              16'h0028
`define OT_F_MIN              16'h0019
`define OT_F_MAX              16'h008C
`define OT_W_MIN              16'h0019
`define OT_W_MAX              16'h007D
`define VIN_MIN               16'h0030
`define VIN_MAX               16'h005A
`define PG_MIN                16'h001E
`define PG_MAX                16'h0084
`define PG_GAP                16'h0005
`define TON_DLY_MIN           16'h0000
`define TON_DLY_MAX           16'h01F4
`define OUTPUT_RISE_TIME_MIN          16'h000F
`define OUTPUT_RISE_TIME_MAX          16'h01F4

// reset values
`define RST_OC_F              16'h002D
`define RST_OC_W              16'h0023
`define RST_OT_F              16'h0078
`define RST_OT_W              16'h006E
`define RST_VIN               16'h0050
`define RST_PG_ON             16'h006C
`define RST_PG_OFF            16'h0064
`define RST_TON_DLY           16'h000A
`define RST_OUTPUT_RISE_TIME          16'h000F
`define RST_OC_REACT          8'hF8
`define RST_OT_REACT          8'hB8
`define RST_VIN_REACT         8'hC0

// reaction byte fields
`define RSP_OC                2'h3
`define RSP_OT                2'h2
`define RS_NEVER              3'h0
`define RS_ALWAYS             3'h7
`define DT_NONE               3'h0

// status bit positions
`define SW_VOUT_BIT           15
`define SW_IOUT_BIT           14
`define SW_INPUT_BIT          13
`define SW_PGOOD_N_BIT        11
`define CML_INV_CMD_BIT       7
`define CML_INV_DATA_BIT      6

// timing
`define CLK_MHZ               250
`define TIME_UNIT_MS          1
`define CYC_WIDTH             18

`endif

// [shared/limit_check_if.sv]
`timescale 1ns/1ps

interface limit_check_if;
  logic [15:0] value;
  logic [15:0] ref_val;
  logic        ok;

  modport checker_end (input value, input ref_val, output ok);
  modport owner_end   (output value, output ref_val, input ok);
endinterface
